/* File: debug_halt_pkg.sv */
/*
  Constants shared by the debug halt control block and its helpers:
  register offsets, field positions, reset values, opcodes, timing.
  Assumes a single 20 MHz core clock and an active-low async reset.
*/
package debug_halt_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  CTRL_ADDR      = 4'h0;
  localparam logic [3:0]  STAT_ADDR      = 4'h1;

  localparam int unsigned HALT_BIT       = 7;
  localparam int unsigned ARM_BIT        = 6;
  localparam int unsigned ACK_BIT        = 5;
  localparam int unsigned RST_BIT        = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  localparam int unsigned ST_HALTED_BIT  = 0;
  localparam int unsigned ST_RST_BIT     = 1;
  localparam int unsigned ST_PROT_BIT    = 2;
  localparam int unsigned ST_BRK_BIT     = 3;
  localparam int unsigned ST_EXEC_BIT    = 4;
  localparam int unsigned ST_DROP_BIT    = 5;
  localparam logic [7:0]  STAT_RESET     = 8'h00;

  // ****************************************************************
  // Opcodes and debug commands
  // ****************************************************************
  localparam logic [7:0]  BRK_OPCODE     = 8'h00;
  localparam logic [7:0]  EXEC_CMD       = 8'h12;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned RESET_PULSE_NS = 1000;
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // Execute command sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    EXEC_IDLE = 2'b00,
    EXEC_FWD  = 2'b01,
    EXEC_DROP = 2'b10
  } exec_state_e;

endpackage

/* File: pulse_timer.sv */
/*
  Fixed-length pulse generator used to hold the device reset.
  Assumes i_start is a one-cycle pulse on the core clock.
*/
module pulse_timer
  import debug_halt_pkg::*;
#(
  parameter int unsigned CYCLES = RESET_PULSE_CYC
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_q;

  // Busy for exactly CYCLES cycles, then one done pulse
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_q <= '0;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy && i_start) begin
        o_busy  <= 1'b1;
        count_q <= CW'(CYCLES - 1);
      end else if (o_busy) begin
        if (count_q == '0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count_q <= count_q - CW'(1);
        end
      end
    end
  end

endmodule

/* File: exec_gate.sv */
/*
  Sequencer for the execute-instruction debug command.
  Assumes command bytes arrive already deframed on the core clock
  and that the CPU flags the last byte of a forwarded opcode.
*/
module exec_gate
  import debug_halt_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_byte_valid,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_protect,
  input  wire logic       i_exec_complete,
  output logic            o_exec_valid,
  output logic [7:0]      o_exec_byte,
  output logic            o_drop,
  output logic            o_busy
);

  exec_state_e state_q;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q      <= EXEC_IDLE;
      o_exec_valid <= 1'b0;
      o_exec_byte  <= 8'h00;
      o_drop       <= 1'b0;
    end else begin
      o_exec_valid <= 1'b0;
      o_drop       <= 1'b0;
      case (state_q)
        EXEC_IDLE: begin
          if (i_byte_valid && i_byte == EXEC_CMD) begin
            state_q <= i_protect ? EXEC_DROP : EXEC_FWD;
          end
        end
        EXEC_FWD: begin
          if (i_byte_valid) begin
            o_exec_valid <= 1'b1;
            o_exec_byte  <= i_byte;
          end
          if (i_exec_complete) begin
            state_q <= EXEC_IDLE;
          end
        end
        EXEC_DROP: begin
          if (i_byte_valid) begin
            o_drop  <= 1'b1;
            state_q <= EXEC_IDLE;
          end
        end
        default: begin
          state_q <= EXEC_IDLE;
        end
      endcase
    end
  end

  assign o_busy = (state_q != EXEC_IDLE);

endmodule

/* File: debug_halt_control.sv */
/*
  Debug halt control: debugger control register, halt flag,
  breakpoint arming, read protection, reset-and-stop / reset-and-go,
  and gating of the execute-instruction debug command.
  Assumes a register port on the core clock shared by software and
  the serial link deframer, a read-protect option level on the same
  clock, and a CPU that reports decoded opcodes one cycle each.
*/
// The placing of the registers and strobed register access were chosen for this implementation.
// Overview of operation
// - Halt flag set stops CPU instruction fetch
// - Clearing halt flag resumes CPU fetch
// - Armed breakpoint opcode decode sets halt flag
// - Read protect ignores halt clear; reset only
// - Bit 6 arms breakpoint; unarmed acts NOP
// - Writing 81H resets and stays halted
// - Writing 41H resets, runs, breakpoints armed
// - Writing 40H while halted resumes, stays armed
// - Protected execute command drops next byte
// - Control reads zero after reset; mixed access
module debug_halt_control
  import debug_halt_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_PULSE_CYC
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [7:0]        o_reg_rdata,
  // Option and CPU side
  input  wire logic              i_read_protect,
  input  wire logic              i_decode_valid,
  input  wire logic [7:0]        i_decode_opcode,
  input  wire logic              i_exec_complete,
  output logic                   o_cpu_fetch_halt,
  output logic                   o_sys_reset,
  output logic                   o_break_hit,
  output logic                   o_break_nop,
  output logic                   o_halt_ack,
  // Debug command bytes from the link deframer
  input  wire logic              i_cmd_valid,
  input  wire logic [7:0]        i_cmd_byte,
  output logic                   o_exec_valid,
  output logic      [7:0]        o_exec_byte
);

  // ****************************************************************
  // Decode of the register port
  // ****************************************************************
  logic ctrl_wr;
  logic stat_wr;
  logic ctrl_rd;
  logic stat_rd;

  assign ctrl_wr = i_reg_wr && (i_reg_addr == CTRL_ADDR);
  assign stat_wr = i_reg_wr && (i_reg_addr == STAT_ADDR);
  assign ctrl_rd = i_reg_rd && (i_reg_addr == CTRL_ADDR);
  assign stat_rd = i_reg_rd && (i_reg_addr == STAT_ADDR);

  // ****************************************************************
  // Control state
  // ****************************************************************
  logic halt_q;
  logic halt_d;
  logic arm_q;
  logic ack_en_q;
  logic brk_seen_q;
  logic drop_seen_q;

  logic rst_busy;
  logic rst_done;
  logic rst_start;
  logic exec_busy;
  logic exec_drop;

  logic brk_decode;
  logic brk_take;
  logic brk_as_nop;

  // ****************************************************************
  // Breakpoint opcode detection
  // ****************************************************************
  assign brk_decode = i_decode_valid && (i_decode_opcode == BRK_OPCODE);

  // Only an armed breakpoint halts; a reset in progress masks decode
  assign brk_take   = brk_decode && arm_q && !halt_q && !rst_busy;

  // Unarmed breakpoint opcode runs on as a no-operation
  assign brk_as_nop = brk_decode && !arm_q;

  // ****************************************************************
  // Halt flag
  // ****************************************************************
  always_comb begin
    halt_d = halt_q;
    if (ctrl_wr) begin
      if (i_reg_wdata[HALT_BIT]) begin
        halt_d = 1'b1;
      end else if (!i_read_protect) begin
        halt_d = 1'b0;
      end
      // Protected clear attempt leaves the flag set
      else begin
        halt_d = halt_q;
      end
    end
    // Hardware set wins over a software clear in the same cycle
    if (brk_take) begin
      halt_d = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      halt_q <= CTRL_RESET[HALT_BIT];
    end else begin
      halt_q <= halt_d;
    end
  end

  // Fetch stall follows the halt flag directly
  assign o_cpu_fetch_halt = halt_q;

  // ****************************************************************
  // Breakpoint arm and acknowledge enable
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arm_q    <= CTRL_RESET[ARM_BIT];
      ack_en_q <= CTRL_RESET[ACK_BIT];
    end else if (ctrl_wr) begin
      // Arm survives the device reset this block requests
      arm_q    <= i_reg_wdata[ARM_BIT];
      ack_en_q <= i_reg_wdata[ACK_BIT];
    end
  end

  // ****************************************************************
  // Device reset request
  // ****************************************************************
  // A new request while one runs is ignored
  assign rst_start = ctrl_wr && i_reg_wdata[RST_BIT] && !rst_busy;

  pulse_timer #(
    .CYCLES (RESET_CYCLES)
  ) u_reset_timer (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_start    (rst_start),
    .o_busy     (rst_busy),
    .o_done     (rst_done)
  );

  // Reset line is the timer's busy flop; bit 0 reads it back
  assign o_sys_reset = rst_busy;

  // ****************************************************************
  // Execute-instruction command gating
  // ****************************************************************
  exec_gate u_exec_gate (
    .i_core_clk      (i_core_clk),
    .i_rst_b         (i_rst_b),
    .i_byte_valid    (i_cmd_valid),
    .i_byte          (i_cmd_byte),
    .i_protect       (i_read_protect),
    .i_exec_complete (i_exec_complete),
    .o_exec_valid    (o_exec_valid),
    .o_exec_byte     (o_exec_byte),
    .o_drop          (exec_drop),
    .o_busy          (exec_busy)
  );

  // ****************************************************************
  // Event pulses toward CPU and link
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_break_hit <= 1'b0;
      o_break_nop <= 1'b0;
      o_halt_ack  <= 1'b0;
    end else begin
      o_break_hit <= brk_take;
      o_break_nop <= brk_as_nop;
      o_halt_ack  <= brk_take && ack_en_q;
    end
  end

  // ****************************************************************
  // Sticky status flags, write one to clear, set wins
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brk_seen_q <= STAT_RESET[ST_BRK_BIT];
    end else if (brk_take) begin
      brk_seen_q <= 1'b1;
    end else if (stat_wr && i_reg_wdata[ST_BRK_BIT]) begin
      brk_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drop_seen_q <= STAT_RESET[ST_DROP_BIT];
    end else if (exec_drop) begin
      drop_seen_q <= 1'b1;
    end else if (stat_wr && i_reg_wdata[ST_DROP_BIT]) begin
      drop_seen_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read-back images
  // ****************************************************************
  logic [7:0] ctrl_image;
  logic [7:0] stat_image;

  // Bits 4..1 are read-only zero
  always_comb begin
    ctrl_image           = 8'h00;
    ctrl_image[HALT_BIT] = halt_q;
    ctrl_image[ARM_BIT]  = arm_q;
    ctrl_image[ACK_BIT]  = ack_en_q;
    ctrl_image[RST_BIT]  = rst_busy;
  end

  always_comb begin
    stat_image                = 8'h00;
    stat_image[ST_HALTED_BIT] = halt_q;
    stat_image[ST_RST_BIT]    = rst_busy;
    stat_image[ST_PROT_BIT]   = i_read_protect;
    stat_image[ST_BRK_BIT]    = brk_seen_q;
    stat_image[ST_EXEC_BIT]   = exec_busy;
    stat_image[ST_DROP_BIT]   = drop_seen_q;
  end

  // ****************************************************************
  // Read data, valid only the cycle after the strobe
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (ctrl_rd) begin
      o_reg_rdata <= ctrl_image;
    end else if (stat_rd) begin
      o_reg_rdata <= stat_image;
    end else begin
      // Unmapped reads and idle cycles return zero
      o_reg_rdata <= 8'h00;
    end
  end

  // rst_done is a spare completion pulse; bit 0 already clears with busy
  logic unused_done;
  assign unused_done = rst_done;

endmodule

/* File: debug_halt_control_asserts.sv */
/*
  Port checker for the debug halt control block.
  Assumes it is bound onto every debug_halt_control instance.
*/
module debug_halt_checker
  import debug_halt_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_PULSE_CYC
) (
  input wire logic              i_core_clk,
  input wire logic              i_rst_b,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0]        i_reg_wdata,
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [7:0]        o_reg_rdata,
  input wire logic              i_read_protect,
  input wire logic              i_decode_valid,
  input wire logic [7:0]        i_decode_opcode,
  input wire logic              o_cpu_fetch_halt,
  input wire logic              o_sys_reset,
  input wire logic              o_break_hit,
  input wire logic              o_break_nop,
  input wire logic              o_halt_ack,
  input wire logic              i_cmd_valid,
  input wire logic [7:0]        i_cmd_byte,
  input wire logic              o_exec_valid,
  input wire logic [7:0]        o_exec_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] rst_len_q;
  logic       ctl_wr;
  logic       breakpoint_opcode;
  assign ctl_wr = i_reg_wr && (i_reg_addr == CTRL_ADDR);
  assign breakpoint_opcode    = i_decode_valid && (i_decode_opcode == BRK_OPCODE);
  // Length of the current device reset request
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) rst_len_q <= 8'h00;
    else if (o_sys_reset) rst_len_q <= rst_len_q + 8'h01;
    else rst_len_q <= 8'h00;
  end
  property p_rst_len; $fell(o_sys_reset) |-> rst_len_q == RESET_CYCLES; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
  property p_wr_rst; ctl_wr && i_reg_wdata[0] && !o_sys_reset |=> o_sys_reset; endproperty
  a_wr_rst: assert property (p_wr_rst) else $error("reset not started");
  property p_halt_set; ctl_wr && i_reg_wdata[7] |=> o_cpu_fetch_halt; endproperty
  a_halt_set: assert property (p_halt_set) else $error("halt not set");
  property p_halt_clr;
    ctl_wr && !i_reg_wdata[7] && !i_read_protect && !breakpoint_opcode |=> !o_cpu_fetch_halt;
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("halt not cleared");
  property p_protect;
    ctl_wr && i_read_protect && o_cpu_fetch_halt |=> o_cpu_fetch_halt;
  endproperty
  a_protect: assert property (p_protect) else $error("protected halt cleared");
  property p_brk;
    breakpoint_opcode && !o_cpu_fetch_halt && !o_sys_reset |=> o_break_hit != o_break_nop;
  endproperty
  a_brk: assert property (p_brk) else $error("break opcode not handled");
  property p_hit; o_break_hit |-> o_cpu_fetch_halt && $past(i_decode_valid); endproperty
  a_hit: assert property (p_hit) else $error("break hit without halt");
  property p_ack; o_halt_ack |-> o_break_hit; endproperty
  a_ack: assert property (p_ack) else $error("ack without break");
  property p_rd0; !$past(i_reg_rd) |-> o_reg_rdata == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside slot");
  property p_exec;
    o_exec_valid |-> $past(i_cmd_valid) && o_exec_byte == $past(i_cmd_byte);
  endproperty
  a_exec: assert property (p_exec) else $error("forwarded byte wrong");
endmodule

bind debug_halt_control debug_halt_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.*);

/* File: debug_host_model.sv */
/*
  Far side model: debug host sending command bytes and the CPU
  reporting decodes and opcode completion.
  Assumes the bench clock; drives just after rising edges.
*/
module debug_host_model (
  input  wire logic i_core_clk,
  output logic       o_cmd_valid,
  output logic [7:0] o_cmd_byte,
  output logic       o_decode_valid,
  output logic [7:0] o_decode_opcode,
  output logic       o_exec_complete
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_byte = 8'h00;
    o_decode_valid = 1'b0;
    o_decode_opcode = 8'hff;
    o_exec_complete = 1'b0;
  end
  // Released byte lanes show the inverse of the last value
  task automatic send_cmd(input logic [7:0] b);
    @(posedge i_core_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_byte <= b;
    @(posedge i_core_clk);
    o_cmd_valid <= 1'b0;
    o_cmd_byte <= ~b;
    #1;
  endtask
  task automatic decode(input logic [7:0] op);
    @(posedge i_core_clk);
    o_decode_valid <= 1'b1;
    o_decode_opcode <= op;
    @(posedge i_core_clk);
    o_decode_valid <= 1'b0;
    o_decode_opcode <= ~op;
    #1;
  endtask
  task automatic complete();
    @(posedge i_core_clk);
    o_exec_complete <= 1'b1;
    @(posedge i_core_clk);
    o_exec_complete <= 1'b0;
    #1;
  endtask
endmodule

/* File: debug_halt_control_tb.sv */
/*
  Self-checking bench for the debug halt control block.
  Assumes the port checker is bound in and the host model drives commands.
*/
module debug_halt_control_tb import debug_halt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RC = 3;
  logic              i_core_clk = 1'b0;
  logic              i_rst_b = 1'b0;
  logic [ADDR_W-1:0] i_reg_addr = '0;
  logic [7:0]        i_reg_wdata = 8'h00;
  logic              i_reg_wr = 1'b0;
  logic              i_reg_rd = 1'b0;
  logic              i_read_protect = 1'b0;
  logic [7:0]        o_reg_rdata, cmd_byte, dec_op, o_exec_byte;
  logic              o_cpu_fetch_halt, o_sys_reset, o_break_hit, o_break_nop, o_halt_ack;
  logic              cmd_valid, dec_valid, exec_done, o_exec_valid;
  int                n_fail = 0;
  int                n_tests = 0;
  always #25 i_core_clk = ~i_core_clk;
  debug_host_model u_host (.i_core_clk, .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte),
    .o_decode_valid(dec_valid), .o_decode_opcode(dec_op), .o_exec_complete(exec_done));
  debug_halt_control #(.RESET_CYCLES(RC)) u_dut (.i_core_clk, .i_rst_b, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_read_protect,
    .i_decode_valid(dec_valid), .i_decode_opcode(dec_op), .i_exec_complete(exec_done),
    .o_cpu_fetch_halt, .o_sys_reset, .o_break_hit, .o_break_nop, .o_halt_ack,
    .i_cmd_valid(cmd_valid), .i_cmd_byte(cmd_byte), .o_exec_valid, .o_exec_byte);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1;
    check(o_reg_rdata & m, exp);
  endtask
  // Counts the device reset request, bounded
  task automatic rst_len();
    int n;
    n = 0;
    while (o_sys_reset === 1'b1 && n < 50) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    check(8'(n), 8'(RC));
    if (n == 50) end_sim();
  endtask
  task automatic t_regs();
    rd_chk(CTRL_ADDR, CTRL_RESET, 8'hff);
    wr(CTRL_ADDR, 8'h3e);
    rd_chk(CTRL_ADDR, 8'h20, 8'hff);
    wr(4'h9, 8'hff);
    rd_chk(4'h9, 8'h00, 8'hff);
    rd_chk(CTRL_ADDR, 8'h20, 8'hff);
    wr(CTRL_ADDR, 8'h00);
  endtask
  task automatic t_nop();
    u_host.decode(BRK_OPCODE);
    check(o_break_nop, 1'b1);
    check(o_cpu_fetch_halt, 1'b0);
  endtask
  task automatic t_go();
    wr(CTRL_ADDR, 8'h80);
    wr(CTRL_ADDR, 8'h41);
    check(o_sys_reset, 1'b1);
    check(o_cpu_fetch_halt, 1'b0);
    rst_len();
    rd_chk(CTRL_ADDR, 8'h40, 8'hff);
    wr(CTRL_ADDR, 8'h60);
    u_host.decode(BRK_OPCODE);
    check(o_break_hit, 1'b1);
    check(o_halt_ack, 1'b1);
    check(o_cpu_fetch_halt, 1'b1);
    rd_chk(CTRL_ADDR, 8'he0, 8'hff);
    rd_chk(STAT_ADDR, 8'h09, 8'h09);
    wr(STAT_ADDR, 8'h08);
    rd_chk(STAT_ADDR, 8'h01, 8'h09);
    wr(CTRL_ADDR, 8'h40);
    check(o_cpu_fetch_halt, 1'b0);
    rd_chk(CTRL_ADDR, 8'h40, 8'hff);
  endtask
  task automatic t_stop();
    wr(CTRL_ADDR, 8'h81);
    check(o_cpu_fetch_halt, 1'b1);
    check(o_sys_reset, 1'b1);
    rst_len();
    rd_chk(CTRL_ADDR, 8'h80, 8'hff);
    @(posedge i_core_clk);
    i_read_protect <= 1'b1;
    wr(CTRL_ADDR, 8'h00);
    check(o_cpu_fetch_halt, 1'b1);
    rd_chk(CTRL_ADDR, 8'h80, 8'hff);
    @(posedge i_core_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    #1;
    check(o_cpu_fetch_halt, 1'b0);
    rd_chk(CTRL_ADDR, CTRL_RESET, 8'hff);
  endtask
  task automatic t_exec();
    u_host.send_cmd(EXEC_CMD);
    u_host.send_cmd(8'h55);
    check(o_exec_valid, 1'b0);
    rd_chk(STAT_ADDR, 8'h20, 8'h20);
    wr(STAT_ADDR, 8'h20);
    rd_chk(STAT_ADDR, 8'h00, 8'h20);
    @(posedge i_core_clk);
    i_read_protect <= 1'b0;
    u_host.send_cmd(EXEC_CMD);
    u_host.send_cmd(8'haa);
    check(o_exec_valid, 1'b1);
    check(o_exec_byte, 8'haa);
    u_host.complete();
  endtask
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_nop();
    t_go();
    t_stop();
    t_exec();
    repeat (3) @(posedge i_core_clk);
    end_sim();
  end
endmodule
